// ---- core/apm_pkg.sv ----
package apm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing, base rate with overspeed factor 1
  localparam int CLK_HZ            = 100_000_000;
  localparam int PDM_RATE_HZ       = 1_000_000;
  localparam int PWM_RATE_HZ_X100  = 2_205_000;
  localparam int CAV_RATE_HZ       = 300;
  localparam int PLL_PDM_RATE_KHZ  = 4230;
  localparam int PDM_DIV_CYC       = CLK_HZ / PDM_RATE_HZ;
  localparam int PWM_PERIOD_CYC    = int'((64'(CLK_HZ) * 64'd100) / 64'(PWM_RATE_HZ_X100));
  localparam int CAV_PERIOD_CYC    = CLK_HZ / CAV_RATE_HZ;
  localparam int PLL_PDM_DIV_CYC   = CLK_HZ / (PLL_PDM_RATE_KHZ * 1000);

  ////////////////////////////////////////////////////////////////////////
  // register indexes, byte address is four times the index
  localparam logic [4:0] IDX_STATUS_SEL = 5'h02;
  localparam logic [4:0] IDX_AUX_DIR    = 5'h03;
  localparam logic [4:0] IDX_MOTOR_MODE = 5'h06;
  localparam logic [4:0] IDX_FUNC_LO    = 5'h0c;
  localparam logic [4:0] IDX_FUNC_HI    = 5'h0d;
  localparam logic [4:0] IDX_STATUS     = 5'h10;

  // field positions
  localparam int DIR_OUT_BIT      = 3;
  localparam int LO_EXT_OFFTRK    = 0;
  localparam int LO_CONST_SEL     = 1;
  localparam int LO_CONST_VAL     = 2;

  // reset values
  localparam logic [3:0] RST_AUX_DIR    = 4'h0;
  localparam logic [3:0] RST_FUNC_LO    = 4'h0;
  localparam logic [3:0] RST_FUNC_HI    = 4'h0;
  localparam logic       RST_STATUS_SEL = 1'b0;

  // servo and carrier scaling
  localparam int FIFO_GAIN        = 8;
  localparam int CAV_NOMINAL_POS  = 12;
  localparam int CAV_SPACE_FRAMES = 20;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {APM_MODE_PDM, APM_MODE_PWM2, APM_MODE_PWM4, APM_MODE_CAV} apm_mode_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } apm_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } apm_axil_rsp_t;

  // symmetric clamp keeps pwm magnitude inside 7 bits
  function automatic logic signed [7:0] apm_sat8(input logic signed [11:0] v);
    if (v > 12'sd127) return 8'sd127;
    else if (v < -12'sd127) return -8'sd127;
    else return v[7:0];
  endfunction

endpackage

// ---- core/apm_motor_out.sv ----
`timescale 1ns/1ps
module apm_motor_out #(
  parameter int OVERSPEED  = 1,
  parameter int PWM_PERIOD = apm_pkg::PWM_PERIOD_CYC,
  parameter int CAV_PERIOD = apm_pkg::CAV_PERIOD_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire apm_pkg::apm_mode_t mode,
  input  wire logic signed [7:0]  drive,
  input  wire logic signed [4:0]  fifo_pos,
  input  wire logic [7:0]         pll_freq,
  output logic                    mot_a,
  output logic                    mot_b,
  output logic                    line_c,
  output logic                    line_d
);
  import apm_pkg::*;

  localparam logic [7:0]  PDM_LAST = 8'(PDM_DIV_CYC / OVERSPEED - 1);
  localparam logic [4:0]  PLL_LAST = 5'(PLL_PDM_DIV_CYC / OVERSPEED - 1);
  localparam int          PWM_N    = PWM_PERIOD / OVERSPEED;
  localparam logic [19:0] PWM_LAST = 20'(PWM_N - 1);
  localparam logic [19:0] CAV_LAST = 20'(CAV_PERIOD - 1);

  typedef struct packed {
    logic [7:0]  pdm_div;
    logic        pdm_tick;
    logic [7:0]  pdm_acc;
    logic [4:0]  pll_div;
    logic        pll_tick;
    logic [7:0]  pll_acc;
    logic [19:0] pwm_cnt;
    logic [19:0] pwm_duty;
    logic        pwm_pos;
    logic        pwm_neg;
    logic [19:0] cav_cnt;
    logic        mot_a;
    logic        mot_b;
    logic        line_c;
    logic        line_d;
  } apm_mot_state_t;

  apm_mot_state_t s_q, s_d;

  always_comb begin
    logic [8:0]  sum;
    logic [6:0]  mag;
    logic [5:0]  cpos;
    logic [19:0] cduty;
    logic        on;
    sum   = 9'h000;
    mag   = drive[7] ? 7'(-drive) : drive[6:0];
    cpos  = 6'(fifo_pos + 5'sd0) + 6'(CAV_NOMINAL_POS);
    cduty = 20'((32'(cpos) * 32'(CAV_PERIOD)) / CAV_SPACE_FRAMES);
    on    = (s_q.pwm_cnt < s_q.pwm_duty);
    s_d   = s_q;
    // enables from dividers, one cycle wide
    s_d.pdm_tick = (s_q.pdm_div == PDM_LAST);
    s_d.pdm_div  = s_d.pdm_tick ? 8'h00 : s_q.pdm_div + 8'h01;
    s_d.pll_tick = (s_q.pll_div == PLL_LAST);
    s_d.pll_div  = s_d.pll_tick ? 5'h00 : s_q.pll_div + 5'h01;
    s_d.cav_cnt  = (s_q.cav_cnt == CAV_LAST) ? 20'h00000 : s_q.cav_cnt + 20'h00001;
    s_d.pwm_cnt  = (s_q.pwm_cnt == PWM_LAST) ? 20'h00000 : s_q.pwm_cnt + 20'h00001;
    // command is sampled once per period so a pulse is never cut short
    if (s_q.pwm_cnt == PWM_LAST) begin
      s_d.pwm_duty = 20'((32'(mag) * 32'(PWM_N)) >> 7);
      s_d.pwm_pos  = (drive > 8'sd0);
      s_d.pwm_neg  = drive[7];
    end
    s_d.line_c = 1'b0;
    s_d.line_d = 1'b0;
    case (mode)
      APM_MODE_PDM: begin
        if (s_q.pdm_tick) begin
          sum = {1'b0, s_q.pdm_acc} + {1'b0, drive ^ 8'h80};
          s_d.pdm_acc = sum[7:0];
          s_d.mot_a   = sum[8];
        end
        s_d.mot_b = ~s_d.mot_a;
      end
      APM_MODE_PWM2, APM_MODE_PWM4: begin
        s_d.mot_a = s_q.pwm_pos & on;
        s_d.mot_b = s_q.pwm_neg & on;
        if (mode == APM_MODE_PWM4) begin
          // low-side legs of the bridge follow the direction
          s_d.line_c = s_q.pwm_pos;
          s_d.line_d = s_q.pwm_neg;
        end
      end
      default: begin
        // servo drive ignored here
        s_d.mot_a = (s_q.cav_cnt < cduty);
        if (s_q.pll_tick) begin
          sum = {1'b0, s_q.pll_acc} + {1'b0, pll_freq};
          s_d.pll_acc = sum[7:0];
          s_d.mot_b   = sum[8];
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end

  assign mot_a  = s_q.mot_a;
  assign mot_b  = s_q.mot_b;
  assign line_c = s_q.line_c;
  assign line_d = s_q.line_d;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pdm_true_compl: assert property (mode == APM_MODE_PDM && $past(mode) == APM_MODE_PDM |-> ##1 mot_b == ~mot_a)
    else $error("pdm lines not complementary");
  a_pdm_tick_edge: assert property ($past(mode) == APM_MODE_PDM && $changed(s_q.mot_a) |-> $past(s_q.pdm_tick))
    else $error("pdm line moved between ticks");
  a_pwm_one_side: assert property (mode inside {APM_MODE_PWM2, APM_MODE_PWM4} |=> !(mot_a && mot_b))
    else $error("both pwm lines active");
  a_pwm_period_wrap: assert property (s_q.pwm_cnt == PWM_LAST |=> s_q.pwm_cnt == 20'h00000)
    else $error("pwm period length wrong");
  a_lines_idle: assert property (mode != APM_MODE_PWM4 |=> !line_c && !line_d)
    else $error("extra lines active outside four-line mode");
  c_pdm_pulse:  cover property (mode == APM_MODE_PDM && $rose(mot_a));
  c_pwm_accel:  cover property (mode == APM_MODE_PWM2 && $rose(mot_a));
  c_pwm_brake:  cover property (mode == APM_MODE_PWM4 && $rose(mot_b));
  c_cav_pulse:  cover property (mode == APM_MODE_CAV && $rose(mot_a));

endmodule // apm_motor_out

// ---- core/apm_aux_motor.sv ----
`timescale 1ns/1ps
// Behaviour
// - the dual pin is an input while direction bit 3 is 0, an open-drain output when 1, and an input after reset.
// - direction and the output function of the dual pin are set independently and a function alone never alters input use.
// - function-low bit 0 high takes the off-track signal from aux pin one, low uses the internal one.
// - software reads aux pin one or the dual pin input through a status bit whose source a select register picks.
// - in output role function-low bits 2:1 give the right silence flag (bit 1 low), a constant 0 (01) or a constant 1 (11).
// - aux pin four gives subcode for 01, 0 for 10, 1 for 11, and the four-line motor leg when function-high is all zero.
// - aux pin five gives the de-emphasis flag high for 01, 0 for 10 and 1 for 11 in function-high bits 3:2.
// - the motor mode register picks pulse density, two-line pwm, four-line pwm or the cav disc motor mode.
// - the drive value comes from the buffer fill position and the measured speed error.
// - in pulse density a half ones density is no drive, more accelerates, less brakes.
// - in pulse density motor line b is always the inverse of motor line a.
// - in pulse density both lines change only on the one megahertz times n enable.
// - in two-line pwm line a carries acceleration and line b braking at 22.05 kHz times n.
// - in four-line pwm aux pins four and five become two more motor drive lines when function-high is all zero.
// - the right silence flag pulls the dual pin low on right-channel silence.
// - in cav disc motor mode line a is pwm of the buffer position, line b pulse density of the pll rate, servo off.
module apm_aux_motor #(
  parameter int OVERSPEED  = 1,
  parameter int PWM_PERIOD = apm_pkg::PWM_PERIOD_CYC,
  parameter int CAV_PERIOD = apm_pkg::CAV_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   RST_N,
  // register bus
  input  wire apm_pkg::apm_axil_req_t AXI_REQ,
  output apm_pkg::apm_axil_rsp_t      AXI_RSP,
  // reconfigurable pins
  input  wire logic                   AUX_PIN_ONE,
  input  wire logic                   DUAL_PIN_INPUT_ROLE,
  output logic                        DUAL_PIN_OUTPUT_ROLE,
  output logic                        DUAL_PIN_OE_N,
  output logic                        AUX_PIN_FOUR,
  output logic                        AUX_PIN_FIVE,
  // decoder side signals
  input  wire logic                   OFFTRACK_INT,
  input  wire logic                   RIGHT_SILENCE,
  input  wire logic                   SUBCODE_QW,
  input  wire logic                   DEEMPH_FLAG,
  output logic                        OFFTRACK_OUT,
  output logic                        DECODER_STATUS,
  // servo measurements
  input  wire logic signed [4:0]      FIFO_POS,
  input  wire logic signed [7:0]      SPEED_ERR,
  input  wire logic [7:0]             PLL_FREQ,
  // motor bridge
  output logic                        MOTOR_OUT_A,
  output logic                        MOTOR_OUT_B
);
  import apm_pkg::*;

  typedef struct packed {
    logic              aw_have;
    logic [7:0]        aw_addr;
    logic              w_have;
    logic [3:0]        w_data;
    logic              w_lane0;
    apm_axil_rsp_t     rsp;
    logic [3:0]        aux_dir;
    logic [3:0]        func_lo;
    logic [3:0]        func_hi;
    logic              status_sel;
    apm_mode_t         motor_mode;
    logic signed [7:0] drive;
    logic              dual_o;
    logic              dual_oe_n;
    logic              aux4;
    logic              aux5;
    logic              offtrack;
    logic              status;
    logic              mot_a;
    logic              mot_b;
  } apm_top_state_t;

  apm_top_state_t s_q, s_d;
  logic           m_a;
  logic           m_b;
  logic           m_c;
  logic           m_d;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_mapped(input logic [7:0] addr);
    logic [4:0] idx;
    idx = addr[6:2];
    if (addr[7] || addr[1:0] != 2'b00) return 1'b0;
    else if (idx == IDX_STATUS_SEL || idx == IDX_AUX_DIR || idx == IDX_MOTOR_MODE) return 1'b1;
    else if (idx == IDX_FUNC_LO || idx == IDX_FUNC_HI || idx == IDX_STATUS) return 1'b1;
    else return 1'b0;
  endfunction

  apm_motor_out #(
    .OVERSPEED  (OVERSPEED),
    .PWM_PERIOD (PWM_PERIOD),
    .CAV_PERIOD (CAV_PERIOD)
  ) u_motor (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .mode     (s_q.motor_mode),
    .drive    (s_q.drive),
    .fifo_pos (FIFO_POS),
    .pll_freq (PLL_FREQ),
    .mot_a    (m_a),
    .mot_b    (m_b),
    .line_c   (m_c),
    .line_d   (m_d)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [4:0]  idx;
    logic [31:0] rd;
    logic        lvl;
    idx = 5'h00;
    rd  = 32'h00000000;
    lvl = 1'b1;
    s_d = s_q;
    // write path: address and data may arrive in either order
    if (s_q.rsp.bvalid && AXI_REQ.bready) s_d.rsp.bvalid = 1'b0;
    if (AXI_REQ.awvalid && s_q.rsp.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && s_q.rsp.wready) begin
      s_d.w_have  = 1'b1;
      s_d.w_data  = AXI_REQ.wdata[3:0];
      s_d.w_lane0 = AXI_REQ.wstrb[0];
    end
    if (s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid) begin
      idx = s_q.aw_addr[6:2];
      s_d.aw_have    = 1'b0;
      s_d.w_have     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = is_mapped(s_q.aw_addr) ? AXI_OKAY : AXI_SLVERR;
      if (!is_mapped(s_q.aw_addr) || !s_q.w_lane0) begin
        s_d.rsp.bresp = s_d.rsp.bresp;
      end else if (idx == IDX_AUX_DIR) begin
        s_d.aux_dir = s_q.w_data;
      end else if (idx == IDX_FUNC_LO) begin
        s_d.func_lo = s_q.w_data;
      end else if (idx == IDX_FUNC_HI) begin
        s_d.func_hi = s_q.w_data;
      end else if (idx == IDX_STATUS_SEL) begin
        s_d.status_sel = s_q.w_data[0];
      end else if (idx == IDX_MOTOR_MODE) begin
        s_d.motor_mode = apm_mode_t'(s_q.w_data[1:0]);
      end
    end
    s_d.rsp.awready = !s_d.aw_have;
    s_d.rsp.wready  = !s_d.w_have;

    // read path: one outstanding read, data one cycle after the address
    if (s_q.rsp.rvalid && AXI_REQ.rready) s_d.rsp.rvalid = 1'b0;
    if (AXI_REQ.arvalid && s_q.rsp.arready) begin
      idx = AXI_REQ.araddr[6:2];
      if (!is_mapped(AXI_REQ.araddr)) rd = 32'h00000000;
      else if (idx == IDX_AUX_DIR) rd = {28'h0000000, s_q.aux_dir};
      else if (idx == IDX_FUNC_LO) rd = {28'h0000000, s_q.func_lo};
      else if (idx == IDX_FUNC_HI) rd = {28'h0000000, s_q.func_hi};
      else if (idx == IDX_STATUS_SEL) rd = {31'h00000000, s_q.status_sel};
      else if (idx == IDX_MOTOR_MODE) rd = {30'h00000000, s_q.motor_mode};
      else rd = {16'h0000, s_q.drive, 5'h00, DUAL_PIN_INPUT_ROLE, AUX_PIN_ONE, s_q.status};
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = rd;
      s_d.rsp.rresp  = is_mapped(AXI_REQ.araddr) ? AXI_OKAY : AXI_SLVERR;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;

    // speed error pushes, a filling buffer means too fast and brakes
    s_d.drive = apm_sat8(12'(SPEED_ERR) - 12'(FIFO_POS) * 12'(FIFO_GAIN));

    s_d.offtrack = s_q.func_lo[LO_EXT_OFFTRK] ? AUX_PIN_ONE : OFFTRACK_INT;
    s_d.status   = s_q.status_sel ? DUAL_PIN_INPUT_ROLE : AUX_PIN_ONE;

    // function is computed even in input role; only the enable looks at direction
    if (!s_q.func_lo[LO_CONST_SEL]) lvl = !RIGHT_SILENCE;
    else lvl = s_q.func_lo[LO_CONST_VAL];
    s_d.dual_o    = 1'b0;
    s_d.dual_oe_n = !(s_q.aux_dir[DIR_OUT_BIT] && !lvl);

    case (s_q.func_hi[1:0])
      2'b01:   s_d.aux4 = SUBCODE_QW;
      2'b10:   s_d.aux4 = 1'b0;
      2'b11:   s_d.aux4 = 1'b1;
      default: s_d.aux4 = (s_q.func_hi == 4'h0) ? m_c : 1'b0;
    endcase
    case (s_q.func_hi[3:2])
      2'b01:   s_d.aux5 = DEEMPH_FLAG;
      2'b10:   s_d.aux5 = 1'b0;
      2'b11:   s_d.aux5 = 1'b1;
      default: s_d.aux5 = (s_q.func_hi == 4'h0) ? m_d : 1'b0;
    endcase

    s_d.mot_a = m_a;
    s_d.mot_b = m_b;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q               <= '0;
      s_q.rsp.awready   <= 1'b1;
      s_q.rsp.wready    <= 1'b1;
      s_q.rsp.arready   <= 1'b1;
      s_q.aux_dir       <= RST_AUX_DIR;
      s_q.func_lo       <= RST_FUNC_LO;
      s_q.func_hi       <= RST_FUNC_HI;
      s_q.status_sel    <= RST_STATUS_SEL;
      s_q.motor_mode    <= APM_MODE_PDM;
      s_q.dual_oe_n     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign AXI_RSP              = s_q.rsp;
  assign DUAL_PIN_OUTPUT_ROLE = s_q.dual_o;
  assign DUAL_PIN_OE_N        = s_q.dual_oe_n;
  assign AUX_PIN_FOUR         = s_q.aux4;
  assign AUX_PIN_FIVE         = s_q.aux5;
  assign OFFTRACK_OUT         = s_q.offtrack;
  assign DECODER_STATUS       = s_q.status;
  assign MOTOR_OUT_A          = s_q.mot_a;
  assign MOTOR_OUT_B          = s_q.mot_b;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_input_role_off: assert property (!s_q.aux_dir[DIR_OUT_BIT] |=> DUAL_PIN_OE_N)
    else $error("dual pin driven in input role");
  a_func_no_effect: assert property (!s_q.aux_dir[DIR_OUT_BIT] ##1 !s_q.aux_dir[DIR_OUT_BIT] |-> DUAL_PIN_OE_N[*2])
    else $error("function setting disturbed input role");
  a_offtrack_pick: assert property (s_q.func_lo[LO_EXT_OFFTRK] |=> OFFTRACK_OUT == $past(AUX_PIN_ONE))
    else $error("external off-track not passed");
  a_status_source: assert property (s_q.status_sel |=> DECODER_STATUS == $past(DUAL_PIN_INPUT_ROLE))
    else $error("status bit source wrong");
  a_dual_const_low: assert property (s_q.aux_dir[DIR_OUT_BIT] && s_q.func_lo[2:1] == 2'b01 |=> !DUAL_PIN_OE_N)
    else $error("constant low not driven");
  a_silence_pull: assert property (s_q.aux_dir[DIR_OUT_BIT] && !s_q.func_lo[1] |=> DUAL_PIN_OE_N == !$past(RIGHT_SILENCE))
    else $error("silence flag not on dual pin");
  a_aux_four_fn: assert property (s_q.func_hi[1:0] == 2'b01 |=> AUX_PIN_FOUR == $past(SUBCODE_QW))
    else $error("aux four not subcode");
  a_aux_five_fn: assert property (s_q.func_hi[3:2] == 2'b10 |=> !AUX_PIN_FIVE)
    else $error("aux five not low");
  a_drive_sign: assert property (FIFO_POS == 5'sd0 && SPEED_ERR > 8'sd0 |=> s_q.drive == $past(SPEED_ERR))
    else $error("drive does not follow speed error");
  c_dual_out:  cover property (!DUAL_PIN_OE_N);
  c_four_line: cover property (s_q.motor_mode == APM_MODE_PWM4 && AUX_PIN_FOUR);
  c_rd_done:   cover property (AXI_RSP.rvalid && AXI_REQ.rready);

endmodule // apm_aux_motor

// ---- sim/apm_bridge_model.sv ----
`timescale 1ns/1ps
// behavioural motor bridge: sums drive time per line like the bridge coils would
module apm_bridge_model #(
  parameter int TICK = 100
) (
  // clock and control
  input  wire logic clk,
  input  wire logic clr,
  // motor lines
  input  wire logic line_a,
  input  wire logic line_b,
  // results
  output int        acc_cnt,
  output int        brk_cnt,
  output int        same_cnt,
  output logic      grid_bad
);
  int   cyc;
  int   ref_c;
  logic a_q;

  // edge grid is anchored on the first edge after clear, phase of the tick is unknown
  always @(posedge clk) begin
    a_q <= line_a;
    cyc <= clr ? 0 : cyc + 1;
    if (clr) begin
      acc_cnt  <= 0;
      brk_cnt  <= 0;
      same_cnt <= 0;
      grid_bad <= 1'b0;
      ref_c    <= -1;
    end else begin
      acc_cnt  <= acc_cnt + int'(line_a);
      brk_cnt  <= brk_cnt + int'(line_b);
      same_cnt <= same_cnt + int'(line_a === line_b);
      if (line_a !== a_q && cyc > 0) begin
        if (ref_c < 0) ref_c <= cyc;
        else if ((cyc - ref_c) % TICK != 0) grid_bad <= 1'b1;
      end
    end
  end
endmodule // apm_bridge_model

// ---- sim/apm_aux_motor_tb.sv ----
`timescale 1ns/1ps
module apm_aux_motor_tb;
  import apm_pkg::*;
  localparam int PWM_P = 256;
  localparam int CAV_P = 1000;
  logic                 ref_clk = 1'b0;
  logic                 rst_n   = 1'b0;
  apm_axil_req_t        req     = '{bready: 1'b1, rready: 1'b1, default: '0};
  apm_axil_rsp_t        rsp;
  logic                 aux_one = 1'b0, ext_low = 1'b0, otk = 1'b0, rsil = 1'b0;
  logic                 subq = 1'b0, demph = 1'b0, clr = 1'b1;
  logic signed [4:0]    fpos = '0;
  logic signed [7:0]    serr = '0;
  logic [7:0]           pll  = 8'h80;
  logic                 dout, oe_n, p4, p5, otk_o, dstat, ma, mb, gbad;
  int                   acc, brk, same;
  int                   bad_count  = 0;
  int                   num_checks = 0;
  // dual pin wire: pull-up unless the device or the bench pulls it low
  wire                  dual_w = (oe_n ? 1'b1 : dout) & ~ext_low;

  always #5 ref_clk = ~ref_clk;

  apm_aux_motor #(.OVERSPEED(1), .PWM_PERIOD(PWM_P), .CAV_PERIOD(CAV_P)) i_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .AXI_REQ(req), .AXI_RSP(rsp),
    .AUX_PIN_ONE(aux_one), .DUAL_PIN_INPUT_ROLE(dual_w), .DUAL_PIN_OUTPUT_ROLE(dout),
    .DUAL_PIN_OE_N(oe_n), .AUX_PIN_FOUR(p4), .AUX_PIN_FIVE(p5), .OFFTRACK_INT(otk),
    .RIGHT_SILENCE(rsil), .SUBCODE_QW(subq), .DEEMPH_FLAG(demph), .OFFTRACK_OUT(otk_o),
    .DECODER_STATUS(dstat), .FIFO_POS(fpos), .SPEED_ERR(serr), .PLL_FREQ(pll),
    .MOTOR_OUT_A(ma), .MOTOR_OUT_B(mb));

  apm_bridge_model #(.TICK(100)) i_bridge (
    .clk(ref_clk), .clr(clr), .line_a(ma), .line_b(mb),
    .acc_cnt(acc), .brk_cnt(brk), .same_cnt(same), .grid_bad(gbad));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // bready and rready stay high, so each answer is taken at the edge it is seen
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    if (n == 40) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end else begin
      chk(32'(rsp.bresp), 32'(er));
    end
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    if (n == 40) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end else begin
      chk(32'(rsp.rresp), 32'(er));
      chk(rsp.rdata, exp);
    end
  endtask

  task automatic meas(input int n);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    cyc(n + 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] adr [5] = '{8'h08, 8'h0c, 8'h18, 8'h30, 8'h34};
    chk(32'(oe_n), 32'h1);
    foreach (adr[i]) axr(adr[i], 32'h0, AXI_OKAY);
    axw(8'h30, 32'h5, AXI_OKAY);
    axr(8'h30, 32'h5, AXI_OKAY);
    axw(8'h3c, 32'h1, AXI_SLVERR);
    axr(8'h3c, 32'h0, AXI_SLVERR);
    $display("test regs done");
  endtask

  task automatic t_dual;
    axw(8'h30, 32'h2, AXI_OKAY);
    cyc(3);
    chk(32'(oe_n), 32'h1);
    axw(8'h0c, 32'h8, AXI_OKAY);
    cyc(3);
    chk(32'(oe_n), 32'h0);
    axw(8'h30, 32'h6, AXI_OKAY);
    cyc(3);
    chk(32'(oe_n), 32'h1);
    axw(8'h30, 32'h4, AXI_OKAY);
    rsil <= 1'b1;
    cyc(3);
    chk(32'(oe_n), 32'h0);
    rsil <= 1'b0;
    cyc(3);
    chk(32'(oe_n), 32'h1);
    rsil <= 1'b1;
    cyc(3);
    chk(32'(oe_n), 32'h0);
    axw(8'h0c, 32'h0, AXI_OKAY);
    cyc(3);
    chk(32'(oe_n), 32'h1);
    rsil <= 1'b0;
    $display("test dual pin done");
  endtask

  task automatic t_stat;
    aux_one <= 1'b1;
    cyc(3);
    chk(32'(dstat), 32'h1);
    axw(8'h08, 32'h1, AXI_OKAY);
    ext_low <= 1'b1;
    cyc(3);
    chk(32'(dstat), 32'h0);
    axr(8'h40, 32'h2, AXI_OKAY);
    ext_low <= 1'b0;
    axw(8'h30, 32'h1, AXI_OKAY);
    cyc(3);
    chk({31'h0, otk_o}, 32'h1);
    axw(8'h30, 32'h0, AXI_OKAY);
    cyc(3);
    chk({31'h0, otk_o}, 32'h0);
    $display("test status done");
  endtask

  task automatic t_hi;
    subq  <= 1'b1;
    demph <= 1'b1;
    axw(8'h34, 32'h5, AXI_OKAY);
    cyc(3);
    chk(32'({p4, p5}), 32'h3);
    demph <= 1'b0;
    axw(8'h34, 32'h9, AXI_OKAY);
    cyc(3);
    chk(32'({p4, p5}), 32'h2);
    axw(8'h34, 32'ha, AXI_OKAY);
    cyc(3);
    chk(32'({p4, p5}), 32'h0);
    axw(8'h34, 32'hf, AXI_OKAY);
    cyc(3);
    chk(32'({p4, p5}), 32'h3);
    $display("test aux high done");
  endtask

  // density tolerance covers the tick phase at the window edges; start-up settles in the wait before the window
  task automatic t_pdm;
    axw(8'h18, 32'h0, AXI_OKAY);
    cyc(300);
    meas(6400);
    chk(32'(acc > 2880 && acc < 3520), 32'h1);
    chk(32'(same), 32'h0);
    chk(32'(gbad), 32'h0);
    fpos <= -5'sd8;
    cyc(300);
    meas(6400);
    chk(32'(acc > 4000), 32'h1);
    fpos <= 5'sd0;
    serr <= -8'sd64;
    cyc(300);
    meas(6400);
    chk(32'(acc < 2400), 32'h1);
    chk(32'(gbad), 32'h0);
    $display("test pulse density done");
  endtask

  task automatic t_pwm;
    axw(8'h18, 32'h1, AXI_OKAY);
    serr <= 8'sd64;
    cyc(600);
    meas(4 * PWM_P);
    chk(32'(acc), 32'(2 * PWM_P));
    chk(32'(brk), 32'h0);
    serr <= -8'sd64;
    cyc(600);
    meas(4 * PWM_P);
    chk(32'(acc), 32'h0);
    chk(32'(brk), 32'(2 * PWM_P));
    axw(8'h34, 32'h0, AXI_OKAY);
    axw(8'h18, 32'h2, AXI_OKAY);
    cyc(600);
    chk(32'({p4, p5}), 32'h1);
    serr <= 8'sd64;
    cyc(600);
    chk(32'({p4, p5}), 32'h2);
    $display("test pwm done");
  endtask

  task automatic t_cav;
    axw(8'h18, 32'h3, AXI_OKAY);
    cyc(1200);
    meas(2 * CAV_P);
    chk(32'(acc), 32'(CAV_P * 12 / 10));
    chk(32'(brk > 800 && brk < 1200), 32'h1);
    $display("test cav done");
  endtask

  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(1);
    t_regs();
    t_dual();
    t_stat();
    t_hi();
    t_pdm();
    t_pwm();
    t_cav();
    give_verdict();
  end
endmodule // apm_aux_motor_tb
